//--- tfps_defs.svh
// tfps_defs.svh: constants for the fan pwm sequencer
// assumes: included by bare name from the package and design files
`ifndef TFPS_DEFS_SVH
`define TFPS_DEFS_SVH
`define TFPS_LEVEL_W      8
`define TFPS_STARTUP_PER  64
`define TFPS_TB_PERIOD_NS 33333333
`define TFPS_CLK_NS       8
`define TFPS_TB_CYCLES    (`TFPS_TB_PERIOD_NS / `TFPS_CLK_NS)
`define TFPS_SPAN_MIN     8'h4d
`define TFPS_FULL_DUTY    8'hb3
`define TFPS_OVERTEMP     8'hc4
`define TFPS_SHUTDOWN     8'h09
`define TFPS_RELEASE      8'h0e
`define TFPS_HYST         8'h1c
`endif

//--- tfps_pkg.sv
// tfps_pkg.sv: types for the fan pwm sequencer
// assumes: tfps_defs.svh on the include path
`include "tfps_defs.svh"
package tfps_pkg;
    typedef enum logic [1:0] {TFPS_SHUT, TFPS_SLEEP, TFPS_START, TFPS_RUN} tfps_state_t;
    typedef struct packed {
        logic [`TFPS_LEVEL_W-1:0] primary_control_level;
        logic [`TFPS_LEVEL_W-1:0] secondary_control_level;
        logic [`TFPS_LEVEL_W-1:0] sleep_threshold;
    } tfps_levels_t;
    typedef struct packed {
        logic fan_out;
        logic fan_oe;
        logic overtemp_fault_n_out;
        logic overtemp_fault_n_oe;
    } tfps_drive_t;
endpackage

//--- tfps_timebase.sv
// tfps_timebase.sv: shared time base, one tick per pwm period, with phase ramp
// assumes: single clock i_clk, synchronous active high reset
`timescale 1ns/10ps
`include "tfps_defs.svh"
module tfps_timebase
    import tfps_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = `TFPS_TB_CYCLES
)(
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    input  wire logic                     i_run,
    output logic                          o_tick,
    output logic [`TFPS_LEVEL_W-1:0]      o_phase
);
    logic [31:0] count;
    logic [31:0] next_count;

    always_comb
    begin
        next_count = count + 32'h1;
        if (!i_run || count >= PERIOD_CYCLES - 1)
        begin
            next_count = 32'h0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            count <= 32'h0;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign o_tick  = i_run && (count == PERIOD_CYCLES - 1);
    // phase ramp spans one full period
    assign o_phase = 8'((64'(count) << `TFPS_LEVEL_W) / 64'(PERIOD_CYCLES));
endmodule

//--- tfps_sequencer.sv
// tfps_sequencer.sv: fan pwm sequencer top with startup, sleep, fault, shutdown
// assumes: levels come from sensor-side converters, unsynchronised; one clock
`timescale 1ns/10ps
`include "tfps_defs.svh"
//
// Overview of operation
// RL1: after power-on drive fan high for exactly 64 time-base periods before modulation.
// RL2: leave sleep when either level exceeds sleep threshold plus hysteresis; start timer.
// RL3: on wake, hold fan high 64 periods without modulating.
// RL4: after startup, duty follows the higher of the two levels.
// RL5: primary above full-duty threshold gives constant drive.
// RL6: primary above overtemp threshold asserts active-low fault; fan stays full.
// RL7: fault clears once primary falls below overtemp; proportional control resumes.
// RL8: both levels below sleep threshold, primary above shutdown: enter sleep.
// RL9: only one level low keeps normal running.
// RL10: primary below shutdown threshold stops everything regardless of secondary.
// RL11: one time base serves sequencing and pwm period.
// RL12: primary above release after shutdown acts as full power-up reset.
// RL13: in sleep the fault is inactive and fan drive released.
// RL14: after reset the fan starts only if a level is above wake threshold.
// RL15: duty maps linearly from span bottom to full duty against a ramp.
module tfps_sequencer
    import tfps_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = `TFPS_TB_CYCLES,
    parameter int unsigned STARTUP_PER   = `TFPS_STARTUP_PER
)(
    input  wire logic          i_clk,
    input  wire logic          i_reset,
    input  wire tfps_levels_t  i_levels,
    output tfps_drive_t        o_drive,
    output tfps_state_t        o_state
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    tfps_levels_t sync1;
    tfps_levels_t lv;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sync1 <= '0;
            lv    <= '0;
        end
        else
        begin
            sync1 <= i_levels;
            lv    <= sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparators
    logic [`TFPS_LEVEL_W-1:0] p;
    logic [`TFPS_LEVEL_W-1:0] s;
    logic [`TFPS_LEVEL_W:0]   wake;
    logic                     shut_lvl;
    logic                     rel_lvl;
    logic                     both_low;
    logic                     any_wake;
    logic                     overtemp;
    logic [`TFPS_LEVEL_W-1:0] ctrl;
    assign p        = lv.primary_control_level;
    assign s        = lv.secondary_control_level;
    assign wake     = {1'b0, lv.sleep_threshold} + {1'b0, `TFPS_HYST};
    assign shut_lvl = p < `TFPS_SHUTDOWN;                                   // [RL10]
    assign rel_lvl  = p > `TFPS_RELEASE;                                    // [RL12]
    assign both_low = (p < lv.sleep_threshold) && (s < lv.sleep_threshold); // [RL8] [RL9]
    assign any_wake = ({1'b0, p} > wake) || ({1'b0, s} > wake);             // [RL2] [RL14]
    assign overtemp = p > `TFPS_OVERTEMP;                                   // [RL6] [RL7]
    assign ctrl     = (p >= s) ? p : s;                                     // [RL4]

    ////////////////////////////////////////////////////////////////////////
    // time base
    tfps_state_t              state;
    tfps_state_t              next_state;
    logic                     tick;
    logic [`TFPS_LEVEL_W-1:0] phase;
    tfps_timebase #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_timebase (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_run   (state == TFPS_START || state == TFPS_RUN),                // [RL11]
        .o_tick  (tick),
        .o_phase (phase)
    );

    ////////////////////////////////////////////////////////////////////////
    // state machine
    logic [7:0]  start_cnt;
    logic [7:0]  next_start_cnt;
    always_comb
    begin
        next_state     = state;
        next_start_cnt = start_cnt;
        case (state)
            TFPS_SHUT:
            begin
                next_start_cnt = 8'h0;
                if (rel_lvl)
                begin
                    next_state = TFPS_SLEEP;                                // [RL12]
                end
            end
            TFPS_SLEEP:
            begin
                next_start_cnt = 8'h0;
                if (any_wake)
                begin
                    next_state = TFPS_START;                                // [RL2] [RL14]
                end
            end
            TFPS_START:
            begin
                if (tick)
                begin
                    next_start_cnt = start_cnt + 8'h1;
                    if (start_cnt == 8'(STARTUP_PER - 1))
                    begin
                        next_state = TFPS_RUN;                              // [RL1] [RL3]
                    end
                end
            end
            TFPS_RUN:
            begin
                if (both_low)
                begin
                    next_state = TFPS_SLEEP;                                // [RL8]
                end
            end
            default:
            begin
                next_state = TFPS_SHUT;
            end
        endcase
        if (shut_lvl)
        begin
            next_state = TFPS_SHUT;                                         // [RL10]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state     <= TFPS_SHUT;
            start_cnt <= 8'h0;
        end
        else
        begin
            state     <= next_state;
            start_cnt <= next_start_cnt;
        end
    end
    assign o_state = state;

    ////////////////////////////////////////////////////////////////////////
    // pwm and outputs
    logic [`TFPS_LEVEL_W-1:0] duty;
    logic [15:0]              scaled;
    tfps_drive_t              next_drive;
    always_comb
    begin
        scaled = 16'h0;
        if (ctrl >= `TFPS_FULL_DUTY)
        begin
            duty = 8'hff;                                                   // [RL5]
        end
        else if (ctrl <= `TFPS_SPAN_MIN)
        begin
            duty = 8'h0;
        end
        else
        begin
            scaled = 16'((16'(ctrl - `TFPS_SPAN_MIN) << 8) / 16'(`TFPS_FULL_DUTY - `TFPS_SPAN_MIN));
            duty   = scaled[7:0];                                           // [RL15]
        end
        next_drive = '0;
        case (state)
            TFPS_START:
            begin
                next_drive.fan_out = 1'b1;                                  // [RL1] [RL3]
                next_drive.fan_oe  = 1'b1;
                next_drive.overtemp_fault_n_oe = overtemp;                  // [RL6] [RL7]
            end
            TFPS_RUN:
            begin
                next_drive.fan_out = (duty == 8'hff) || (phase < duty);     // [RL4] [RL15]
                next_drive.fan_oe  = 1'b1;
                next_drive.overtemp_fault_n_oe = overtemp;                  // [RL6] [RL7]
            end
            TFPS_SLEEP:
            begin
                next_drive = '0;                                            // [RL13]
            end
            default:
            begin
                next_drive = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_drive <= '0;
        end
        else
        begin
            o_drive <= next_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_shutdown_all_off;
        @(posedge i_clk) disable iff (i_reset)
        shut_lvl |=> ##1 (o_drive == '0);
    endproperty
    a_shutdown_all_off: assert property (p_shutdown_all_off) else $error("drive active in shutdown"); // [RL10]

    property p_start_high;
        @(posedge i_clk) disable iff (i_reset)
        (state == TFPS_START) |=> o_drive.fan_out && o_drive.fan_oe;
    endproperty
    a_start_high: assert property (p_start_high) else $error("fan not high during startup"); // [RL1]

    sequence s_wake;
        (state == TFPS_SLEEP) && any_wake && !shut_lvl;
    endsequence
    property p_wake_start;
        @(posedge i_clk) disable iff (i_reset)
        s_wake |=> (state == TFPS_START);
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("wake did not start timer"); // [RL2] [RL3]

    property p_fault;
        @(posedge i_clk) disable iff (i_reset)
        (state == TFPS_RUN || state == TFPS_START) && overtemp |=> o_drive.overtemp_fault_n_oe;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not asserted"); // [RL6]

    property p_fault_clear;
        @(posedge i_clk) disable iff (i_reset)
        !overtemp |=> !o_drive.overtemp_fault_n_oe;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared"); // [RL7]

    property p_full_duty;
        @(posedge i_clk) disable iff (i_reset)
        (state == TFPS_RUN) && (p >= `TFPS_FULL_DUTY) |=> o_drive.fan_out;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("not full duty"); // [RL5]

    property p_sleep_enter;
        @(posedge i_clk) disable iff (i_reset)
        (state == TFPS_RUN) && both_low && !shut_lvl |=> (state == TFPS_SLEEP);
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered"); // [RL8]

    property p_one_low_runs;
        @(posedge i_clk) disable iff (i_reset)
        (state == TFPS_RUN) && !both_low && !shut_lvl |=> (state == TFPS_RUN);
    endproperty
    a_one_low_runs: assert property (p_one_low_runs) else $error("left run with one level high"); // [RL9]

    property p_sleep_released;
        @(posedge i_clk) disable iff (i_reset)
        (state == TFPS_SLEEP) |=> !o_drive.fan_oe && !o_drive.overtemp_fault_n_oe;
    endproperty
    a_sleep_released: assert property (p_sleep_released) else $error("drive active in sleep"); // [RL13]

    property p_release_reset;
        @(posedge i_clk) disable iff (i_reset)
        (state == TFPS_SHUT) && rel_lvl && !shut_lvl |=> (state == TFPS_SLEEP);
    endproperty
    a_release_reset: assert property (p_release_reset) else $error("no reset on release"); // [RL12] [RL14]
endmodule

//--- tfps_fan_model.sv
// tfps_fan_model.sv: fan transistor and fault pull-up at the far side of the pins
// assumes: fed straight from the sequencer drive struct
`timescale 1ns/10ps
module tfps_fan_model
    import tfps_pkg::*;
(
    input  wire tfps_drive_t i_drive,
    output logic             o_fan_on,
    output logic             o_fault_pin_n
);
    // base pull-down stops the fan when released
    assign o_fan_on      = i_drive.fan_oe ? i_drive.fan_out : 1'b0;
    // open-drain fault line with pull-up
    assign o_fault_pin_n = i_drive.overtemp_fault_n_oe ? i_drive.overtemp_fault_n_out : 1'b1;
endmodule

//--- tb_top.sv
// tb_top.sv: self-checking bench for the fan pwm sequencer
// assumes: short time base of 8 clocks, inputs driven on falling edge
`timescale 1ns/10ps
`include "tfps_defs.svh"
module tb_top
    import tfps_pkg::*;
;
    localparam int PER = 8;
    logic         i_clk       = 1'b0;
    logic         i_reset     = 1'b1;
    tfps_levels_t lv          = '0;
    tfps_drive_t  drv;
    tfps_state_t  st;
    tfps_state_t  ms          = TFPS_SHUT;
    logic         fan_on;
    logic         fault_n;
    int           err_total   = 0;
    int           checks_done = 0;
    int           cyc         = 0;
    logic [31:0]  rng         = 32'h0000d336;

    always #4 i_clk = ~i_clk;

    tfps_sequencer #(.PERIOD_CYCLES(PER), .STARTUP_PER(64)) dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_levels(lv), .o_drive(drv), .o_state(st));
    tfps_fan_model fan (.i_drive(drv), .o_fan_on(fan_on), .o_fault_pin_n(fault_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference state, end of startup handled by the caller
    task automatic model();
        int p;
        int s;
        int w;
        p = lv.primary_control_level;
        s = lv.secondary_control_level;
        w = lv.sleep_threshold + `TFPS_HYST;
        if (p < `TFPS_SHUTDOWN)
            ms = TFPS_SHUT;
        else
        begin
            if (ms == TFPS_SHUT && p > `TFPS_RELEASE)
                ms = TFPS_SLEEP;
            if (ms == TFPS_SLEEP && (p > w || s > w))
                ms = TFPS_START;
            if (ms == TFPS_RUN && p < lv.sleep_threshold && s < lv.sleep_threshold)
                ms = TFPS_SLEEP;
        end
    endtask

    task automatic setlv(input logic [7:0] p, input logic [7:0] s);
        lv.primary_control_level   = p;
        lv.secondary_control_level = s;
        model();
        repeat (8) @(negedge i_clk);
    endtask

    // fan-on cycles while starting up
    task automatic startup();
        int n;
        n = 0;
        while (st === TFPS_START && n < 600)
        begin
            if (fan_on === 1'b1)
                n++;
            @(negedge i_clk);
        end
        ms = TFPS_RUN;
        chk(8'((n + 6) / PER), 8'd64);
    endtask

    task automatic duty(input logic [7:0] p, input logic [7:0] s);
        int c;
        int d;
        int e;
        int h;
        setlv(p, s);
        repeat (8) @(negedge i_clk);
        c = (p > s) ? p : s;
        d = (c >= `TFPS_FULL_DUTY) ? 256 : (c <= `TFPS_SPAN_MIN) ? 0 :
            (c - `TFPS_SPAN_MIN) * 256 / (`TFPS_FULL_DUTY - `TFPS_SPAN_MIN);
        e = 0;
        h = 0;
        for (int k = 0; k < PER; k++)
        begin
            if (k * 256 / PER < d)
                e++;
            if (fan_on === 1'b1)
                h++;
            @(negedge i_clk);
        end
        chk(8'(h), 8'(e));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        lv.sleep_threshold = 8'h20;
        repeat (10) @(negedge i_clk);
        chk(8'(st), 8'(TFPS_SHUT));
        i_reset = 1'b0;
        setlv(8'h30, 8'h00);
        chk(8'(st), 8'(ms));
        chk(8'(fan_on), 8'h00);
        setlv(8'h80, 8'h00);
        chk(8'(st), 8'(ms));
        startup();
        duty(8'h60, 8'h90);
        duty(8'h90, 8'h60);
        duty(8'hb3, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            rng = xs(rng);
            duty(8'h4d + 8'(rng % 32'h77), 8'h4d + 8'(rng[31:16] % 16'h0077));
        end
        duty(8'hd0, 8'h00);
        chk(8'(fault_n), 8'h00);
        duty(8'h90, 8'h00);
        chk(8'(fault_n), 8'h01);
        setlv(8'h10, 8'h90);
        chk(8'(st), 8'(ms));
        setlv(8'h10, 8'h10);
        chk(8'(st), 8'(ms));
        chk(8'({drv.fan_oe, drv.overtemp_fault_n_oe}), 8'h00);
        setlv(8'h10, 8'h3c);
        chk(8'(st), 8'(ms));
        setlv(8'h10, 8'h3d);
        chk(8'(st), 8'(ms));
        startup();
        setlv(8'hd0, 8'h00);
        setlv(8'h05, 8'hff);
        chk(8'(st), 8'(ms));
        chk(8'(drv), 8'h00);
        setlv(8'h80, 8'h00);
        chk(8'(st), 8'(ms));
        chk(8'(fault_n), 8'h01);
        startup();
        test_done();
    end
endmodule
